// ==== hdl/controlled_stop_standstill_monitor.v ====
// Overview of operation
// - low request input starts stop, high releases
// - stop_active high while function is active
// - standstill_ok high at standstill, low on violation
// - standstill_ok low while function inactive
// - ramp source selectable, drive-activated by default
// - drive mode: send ramp, command drive braking
// - controller mode: fieldbus braking start signal
// - any error invokes stop_then_torque_off instead
// - ramp monitoring optional, off after reset
// - ramp position deviation beyond window faults
// - brake ramp range, minimum two when monitored
// - standstill monitoring by maximum time at latest
// - odd times expire at next cycle boundary
// - standstill window exceeded invokes torque-off stop
// - standstill_ok asserted when standstill monitoring starts
// - optional early standstill below speed limit
// - axis one or two selectable, axis one default
//
// The AXI4-Lite interface to the registers and the address map were left to the implementer.
`timescale 1ns/100ps
`include "controlled_stop_consts.vh"
module controlled_stop_standstill_monitor #(
  parameter MS_CLKS  = `MS_CLKS,
  parameter CYCLE_MS = `SYS_CYCLE_MS
) (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire        stop_request_n,
  input  wire [31:0] axis1_pos,
  input  wire [31:0] axis1_speed,
  input  wire [31:0] axis1_ramp_pos,
  input  wire [31:0] axis2_pos,
  input  wire [31:0] axis2_speed,
  input  wire [31:0] axis2_ramp_pos,
  output reg         stop_active,
  output reg         standstill_ok,
  output reg         drive_brake_start,
  output reg  [31:0] drive_brake_ramp,
  output reg         fieldbus_brake_start,
  output reg         stop_then_torque_off,
  output reg         axis2_selected,
  output reg         irq
);

  // ==========================================================
  // states
  localparam [1:0] ST_IDLE  = 2'h0;
  localparam [1:0] ST_BRAKE = 2'h1;
  localparam [1:0] ST_HOLD  = 2'h2;
  localparam [1:0] ST_FAULT = 2'h3;

  // ==========================================================
  // helpers
  function [32:0] abs_diff;
    input [31:0] a;
    input [31:0] b;
    reg   [32:0] d;
    begin
      d = {a[31], a} - {b[31], b};
      abs_diff = d[32] ? (33'h0 - d) : d;
    end
  endfunction

  function [31:0] merge;
    input [31:0] old;
    input [31:0] data;
    input [3:0]  strb;
    integer i;
    begin
      merge = old;
      for (i = 0; i < 4; i = i + 1) begin
        if (strb[i])
          merge[i*8 +: 8] = data[i*8 +: 8];
      end
    end
  endfunction

  // ==========================================================
  // registers
  reg  [31:0] ctrl;
  reg  [31:0] dec_win;
  reg  [31:0] brake_ramp;
  reg  [31:0] tmax;
  reg  [31:0] tol;
  reg  [31:0] vlim;
  reg  [3:0]  irq_stat;
  reg  [3:0]  irq_en;
  reg  [3:0]  events;
  reg  [1:0]  state;

  // ==========================================================
  // request synchroniser; only req_sync is read by logic
  reg req_meta;
  reg req_sync;
  always @(posedge aclk) begin
    if (!aresetn) begin
      req_meta <= 1'b1;
      req_sync <= 1'b1;
    end else begin
      req_meta <= stop_request_n;
      req_sync <= req_meta;
    end
  end

  // ==========================================================
  // millisecond and processing cycle ticks, free running so
  // time checks land only on cycle boundaries
  reg [31:0] ms_cnt;
  reg [31:0] cyc_cnt;
  reg        ms_tick;
  reg        sys_tick;
  always @(posedge aclk) begin
    if (!aresetn) begin
      ms_cnt   <= 32'h0;
      cyc_cnt  <= 32'h0;
      ms_tick  <= 1'b0;
      sys_tick <= 1'b0;
    end else begin
      ms_tick  <= 1'b0;
      sys_tick <= 1'b0;
      if (ms_cnt == MS_CLKS - 1) begin
        ms_cnt  <= 32'h0;
        ms_tick <= 1'b1;
        if (cyc_cnt == CYCLE_MS - 1) begin
          cyc_cnt  <= 32'h0;
          sys_tick <= 1'b1;
        end else begin
          cyc_cnt <= cyc_cnt + 32'h1;
        end
      end else begin
        ms_cnt <= ms_cnt + 32'h1;
      end
    end
  end

  // ==========================================================
  // axis selection
  wire [31:0] pos   = ctrl[`CTRL_AXIS2] ? axis2_pos : axis1_pos;
  wire [31:0] speed = ctrl[`CTRL_AXIS2] ? axis2_speed : axis1_speed;
  wire [31:0] rpos  = ctrl[`CTRL_AXIS2] ? axis2_ramp_pos : axis1_ramp_pos;

  // ==========================================================
  // stop sequence
  reg  [31:0] elapsed_ms;
  reg  [31:0] hold_pos;
  wire        ramp_ext = ctrl[`CTRL_RAMP_EXT];
  wire        ramp_bad = ctrl[`CTRL_RAMP_MON] &&
                         (abs_diff(pos, rpos) > {1'b0, dec_win});
  wire        slow     = ctrl[`CTRL_AUTO_SS] &&
                         (abs_diff(speed, 32'h0) < {1'b0, vlim});
  wire        hold_bad = abs_diff(pos, hold_pos) > {1'b0, tol};
  // the cycle tick always lands with a millisecond tick, so count it now;
  // otherwise every even maximum time above zero would run one processing cycle, two milliseconds, long
  wire [32:0] elapsed_now = {1'b0, elapsed_ms} + 33'h1;
  reg  [1:0]  next_state;

  always @* begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (!req_sync)
          next_state = ST_BRAKE;
      end
      ST_BRAKE: begin
        if (req_sync)
          next_state = ST_IDLE;
        else if (ramp_bad)
          next_state = ST_FAULT;
        else if (elapsed_now >= {1'b0, tmax} || slow)
          next_state = ST_HOLD;
      end
      ST_HOLD: begin
        if (req_sync)
          next_state = ST_IDLE;
        else if (hold_bad)
          next_state = ST_FAULT;
      end
      ST_FAULT: begin
        if (req_sync)
          next_state = ST_IDLE;
      end
      default: next_state = ST_IDLE;
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      state                <= ST_IDLE;
      elapsed_ms           <= 32'h0;
      hold_pos             <= 32'h0;
      events               <= 4'h0;
      stop_active          <= 1'b0;
      standstill_ok        <= 1'b0;
      drive_brake_start    <= 1'b0;
      drive_brake_ramp     <= `RST_BRAKE_RAMP;
      fieldbus_brake_start <= 1'b0;
      stop_then_torque_off <= 1'b0;
      axis2_selected       <= 1'b0;
    end else begin
      events         <= 4'h0;
      axis2_selected <= ctrl[`CTRL_AXIS2];
      if (state == ST_BRAKE && ms_tick && elapsed_ms != 32'hFFFFFFFF)
        elapsed_ms <= elapsed_ms + 32'h1;
      if (sys_tick) begin
        state <= next_state;
        if (next_state == ST_BRAKE && state == ST_IDLE) begin
          elapsed_ms       <= 32'h0;
          drive_brake_ramp <= brake_ramp;
          events[`IRQ_BRAKE] <= 1'b1;
        end
        if (next_state == ST_HOLD && state == ST_BRAKE) begin
          hold_pos <= pos;
          events[`IRQ_STANDSTILL] <= 1'b1;
        end
        if (next_state == ST_FAULT && state != ST_FAULT)
          events[`IRQ_FAULT] <= 1'b1;
        if (next_state == ST_IDLE && state != ST_IDLE)
          events[`IRQ_RELEASE] <= 1'b1;
        stop_active   <= (next_state != ST_IDLE);
        standstill_ok <= (next_state == ST_HOLD);
        // braking command held until release; fault replaces it
        drive_brake_start <= !ramp_exp_sel(next_state, 1'b0);
        fieldbus_brake_start <= ramp_exp_sel(next_state, 1'b1);
        stop_then_torque_off <= (next_state == ST_FAULT);
      end
    end
  end

  // fieldbus braking command, or the inverse of the drive command; braking only in brake or hold
  function ramp_exp_sel;
    input [1:0] st;
    input       want_ext;
    reg         braking;
    begin
      braking = (st == ST_BRAKE) || (st == ST_HOLD);
      if (want_ext)
        ramp_exp_sel = braking && ramp_ext;
      else
        ramp_exp_sel = !(braking && !ramp_ext);
    end
  endfunction

  // ==========================================================
  // write channel: address and data taken in either order
  reg  [7:0]  aw_addr;
  reg  [31:0] w_data;
  reg  [3:0]  w_strb;
  reg         aw_full;
  reg         w_full;
  wire        wr_do  = aw_full && w_full && !s_axi_bvalid;
  wire [31:0] wr_val = merge(32'h0, w_data, w_strb);
  wire [3:0]  clr    = (wr_do && aw_addr == `OFF_IRQ_CLR) ?
                       wr_val[3:0] : 4'h0;
  reg  [31:0] new_val;
  reg         wr_err;

  always @* begin
    new_val = 32'h0;
    wr_err  = 1'b0;
    case (aw_addr)
      `OFF_CTRL: begin
        new_val = merge(ctrl, w_data, w_strb) & `MASK_CTRL;
        // monitoring cannot be switched on over a too-flat ramp
        if (new_val[`CTRL_RAMP_MON] && brake_ramp < `RAMP_MIN_MON)
          wr_err = 1'b1;
      end
      `OFF_DEC_WIN: new_val = merge(dec_win, w_data, w_strb) & `MASK_31;
      `OFF_BRAKE_RAMP: begin
        new_val = merge(brake_ramp, w_data, w_strb) & `MASK_31;
        if (ctrl[`CTRL_RAMP_MON] && new_val < `RAMP_MIN_MON)
          wr_err = 1'b1;
      end
      `OFF_TMAX: begin
        new_val = merge(tmax, w_data, w_strb) & `MASK_TMAX;
        if (new_val > `TMAX_LIMIT)
          wr_err = 1'b1;
      end
      `OFF_TOL:    new_val = merge(tol, w_data, w_strb) & `MASK_31;
      `OFF_VLIM:   new_val = merge(vlim, w_data, w_strb) & `MASK_VLIM;
      `OFF_IRQ_EN: new_val = merge({28'h0, irq_en}, w_data, w_strb) & `MASK_IRQ;
      `OFF_IRQ_CLR: new_val = 32'h0;
      default:     wr_err = 1'b1;
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `RESP_OKAY;
      aw_full       <= 1'b0;
      w_full        <= 1'b0;
      aw_addr       <= 8'h0;
      w_data        <= 32'h0;
      w_strb        <= 4'h0;
      ctrl          <= `RST_CTRL;
      dec_win       <= `RST_DEC_WIN;
      brake_ramp    <= `RST_BRAKE_RAMP;
      tmax          <= `RST_TMAX;
      tol           <= `RST_TOL;
      vlim          <= `RST_VLIM;
      irq_en        <= 4'h0;
      irq_stat      <= 4'h0;
      irq           <= 1'b0;
    end else begin
      // a new event wins over a clear in the same cycle
      irq_stat <= (irq_stat & ~clr) | events;
      irq      <= |(((irq_stat & ~clr) | events) & irq_en);
      if (s_axi_awvalid && s_axi_awready) begin
        aw_addr       <= {s_axi_awaddr[7:2], 2'b00};
        aw_full       <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_data       <= s_axi_wdata;
        w_strb       <= s_axi_wstrb;
        w_full       <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (wr_do) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_err ? `RESP_SLVERR : `RESP_OKAY;
        if (!wr_err) begin
          case (aw_addr)
            `OFF_CTRL:       ctrl       <= new_val;
            `OFF_DEC_WIN:    dec_win    <= new_val;
            `OFF_BRAKE_RAMP: brake_ramp <= new_val;
            `OFF_TMAX:       tmax       <= new_val;
            `OFF_TOL:        tol        <= new_val;
            `OFF_VLIM:       vlim       <= new_val;
            `OFF_IRQ_EN:     irq_en     <= new_val[3:0];
            default:         ;
          endcase
        end
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        aw_full       <= 1'b0;
        w_full        <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // ==========================================================
  // read channel
  reg [31:0] rd_val;
  reg        rd_err;
  always @* begin
    rd_err = 1'b0;
    case ({s_axi_araddr[7:2], 2'b00})
      `OFF_CTRL:       rd_val = ctrl;
      `OFF_DEC_WIN:    rd_val = dec_win;
      `OFF_BRAKE_RAMP: rd_val = brake_ramp;
      `OFF_TMAX:       rd_val = tmax;
      `OFF_TOL:        rd_val = tol;
      `OFF_VLIM:       rd_val = vlim;
      `OFF_STATUS:     rd_val = {26'h0, stop_then_torque_off, standstill_ok,
                                 stop_active, req_sync, state};
      `OFF_IRQ_STAT:   rd_val = {28'h0, irq_stat};
      `OFF_IRQ_CLR:    rd_val = 32'h0;
      `OFF_IRQ_EN:     rd_val = {28'h0, irq_en};
      default: begin
        rd_val = 32'h0;
        rd_err = 1'b1;
      end
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= `RESP_OKAY;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= rd_val;
        s_axi_rresp   <= rd_err ? `RESP_SLVERR : `RESP_OKAY;
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

endmodule

// ==== pkg/controlled_stop_consts.vh ====
`ifndef CONTROLLED_STOP_CONSTS_VH
`define CONTROLLED_STOP_CONSTS_VH
// ==========================================================
// register byte offsets
`define OFF_CTRL       8'h00
`define OFF_DEC_WIN    8'h04
`define OFF_BRAKE_RAMP 8'h08
`define OFF_TMAX       8'h0C
`define OFF_TOL        8'h10
`define OFF_VLIM       8'h14
`define OFF_STATUS     8'h18
`define OFF_IRQ_STAT   8'h1C
`define OFF_IRQ_CLR    8'h20
`define OFF_IRQ_EN     8'h24
// ==========================================================
// control field positions
`define CTRL_RAMP_EXT  0
`define CTRL_RAMP_MON  1
`define CTRL_AUTO_SS   2
`define CTRL_AXIS2     3
// ==========================================================
// field widths as masks
`define MASK_31        32'h7FFFFFFF
`define MASK_TMAX      32'h0001FFFF
`define MASK_VLIM      32'h00FFFFFF
`define MASK_CTRL      32'h0000000F
`define MASK_IRQ       32'h0000000F
// ==========================================================
// reset values and limits
`define RST_CTRL       32'h00000000
`define RST_DEC_WIN    32'h00000000
`define RST_BRAKE_RAMP 32'h00989680
`define RST_TMAX       32'h00000064
`define RST_TOL        32'h00000064
`define RST_VLIM       32'h00000154
`define RAMP_MIN_MON   32'h00000002
`define TMAX_LIMIT     32'h0001D4C0
// ==========================================================
// interrupt bit positions
`define IRQ_BRAKE      0
`define IRQ_STANDSTILL 1
`define IRQ_FAULT      2
`define IRQ_RELEASE    3
// ==========================================================
// timing
`define CLK_PERIOD_NS  100
`define MS_NS          1000000
`define MS_CLKS        (`MS_NS / `CLK_PERIOD_NS)
`define SYS_CYCLE_MS   2
// ==========================================================
// bus responses
`define RESP_OKAY      2'h0
`define RESP_SLVERR    2'h2
`endif

// ==== sim/controlled_stop_standstill_monitor_props.sv ====
`timescale 1ns/100ps
// ==========================================
// port checks
module controlled_stop_props #(
  parameter MS_CLKS  = 4,
  parameter CYCLE_MS = 2
) (
  input wire        aclk,
  input wire        aresetn,
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  input wire [1:0]  s_axi_bresp,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready,
  input wire [31:0] s_axi_rdata,
  input wire        stop_request_n,
  input wire        stop_active,
  input wire        standstill_ok,
  input wire        drive_brake_start,
  input wire        fieldbus_brake_start,
  input wire        stop_then_torque_off
);
  // counts assume 8 clocks per processing cycle
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_start; !stop_request_n [*8] ##1 !stop_request_n [*6] |-> stop_active; endproperty
  a_start: assert property (p_start) else $error("stop not started");
  property p_rel;
    stop_request_n [*8] ##1 stop_request_n [*6] |-> !stop_active && !standstill_ok;
  endproperty
  a_rel: assert property (p_rel) else $error("stop not released");
  property p_idle_ss; !stop_active |-> !standstill_ok; endproperty
  a_idle_ss: assert property (p_idle_ss) else $error("standstill while inactive");
  property p_ss_rise; $rose(standstill_ok) |-> $past(stop_active) && !stop_then_torque_off;
  endproperty
  a_ss_rise: assert property (p_ss_rise) else $error("standstill without braking");
  property p_fault;
    stop_then_torque_off |-> stop_active && !standstill_ok && !drive_brake_start
      && !fieldbus_brake_start;
  endproperty
  a_fault: assert property (p_fault) else $error("fault outputs wrong");
  property p_drive; drive_brake_start |-> stop_active && !fieldbus_brake_start; endproperty
  a_drive: assert property (p_drive) else $error("drive brake outside stop");
  property p_fbus; fieldbus_brake_start |-> stop_active && !drive_brake_start; endproperty
  a_fbus: assert property (p_fbus) else $error("fieldbus brake outside stop");
  property p_cycle; $changed(stop_active) |=> $stable(stop_active) [*7]; endproperty
  a_cycle: assert property (p_cycle) else $error("change off cycle boundary");
  property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_bhold: assert property (p_bhold) else $error("write response dropped");
  property p_rhold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_rhold: assert property (p_rhold) else $error("read data dropped");
  c_ss: cover property ($rose(standstill_ok));
  c_fault: cover property ($rose(stop_then_torque_off));
  c_fbus: cover property ($rose(fieldbus_brake_start));
endmodule
bind controlled_stop_standstill_monitor controlled_stop_props #(
  .MS_CLKS(MS_CLKS), .CYCLE_MS(CYCLE_MS)) props_u (
  .aclk(aclk), .aresetn(aresetn), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata), .stop_request_n(stop_request_n),
  .stop_active(stop_active), .standstill_ok(standstill_ok),
  .drive_brake_start(drive_brake_start), .fieldbus_brake_start(fieldbus_brake_start),
  .stop_then_torque_off(stop_then_torque_off));

// ==== sim/controlled_stop_standstill_monitor_tb.sv ====
`timescale 1ns/100ps
`include "controlled_stop_consts.vh"
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin num_errors++; \
  $display("CHECK FAILED %0t got %h want %h", $time, a, b); end end
module controlled_stop_standstill_monitor_tb;
  reg         aclk;
  reg         aresetn;
  reg  [7:0]  awaddr;
  reg  [7:0]  araddr;
  reg  [31:0] wdata;
  reg         awvalid, wvalid, bready, arvalid, rready, stop_n, sel2;
  reg  [31:0] skew, noise, d;
  wire        awready, wready, bvalid, arready, rvalid;
  wire [1:0]  bresp, rresp;
  wire [31:0] rdata, ramp, pos, speed, rpos;
  wire        stop_active, standstill_ok, dbs, fbs, sto, ax2, irq;
  wire [2:0]  obs = {sto, standstill_ok, stop_active};
  logic [31:0] rd;
  logic [1:0]  rs;
  int          num_errors, total_checks, n, t, nt[5];
  logic [7:0]  ra[6] = '{`OFF_CTRL, `OFF_DEC_WIN, `OFF_BRAKE_RAMP, `OFF_TMAX, `OFF_TOL, `OFF_VLIM};
  logic [31:0] rv[6] = '{`RST_CTRL, `RST_DEC_WIN, `RST_BRAKE_RAMP, `RST_TMAX, `RST_TOL,
                         `RST_VLIM};
  always #50 aclk = ~aclk;
  function [31:0] lfsr(input [31:0] v);
    lfsr = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  always @(posedge aclk) noise <= lfsr(noise);
  motion_model part_u (.aclk(aclk), .aresetn(aresetn), .brake(dbs | fbs), .skew(skew),
    .pos(pos), .speed(speed), .ramp_pos(rpos));
  controlled_stop_standstill_monitor #(.MS_CLKS(4), .CYCLE_MS(2)) dut_u (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .stop_request_n(stop_n), .axis1_pos(sel2 ? noise : pos),
    .axis1_speed(sel2 ? noise : speed), .axis1_ramp_pos(sel2 ? noise : rpos),
    .axis2_pos(sel2 ? pos : noise), .axis2_speed(sel2 ? speed : noise),
    .axis2_ramp_pos(sel2 ? rpos : noise), .stop_active(stop_active),
    .standstill_ok(standstill_ok), .drive_brake_start(dbs), .drive_brake_ramp(ramp),
    .fieldbus_brake_start(fbs), .stop_then_torque_off(sto), .axis2_selected(ax2), .irq(irq));
  // ==========================================
  // bus tasks, waits and verdict
  task end_sim;
    if (num_errors == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task wr(input [7:0] a, input [31:0] v, output [1:0] r);
    int k;
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    r = bresp;
    bready <= 1'b0;
    if (k == 50) num_errors++;
  endtask
  task chk_rd(input [7:0] a, input [31:0] v, input [1:0] r);
    int k;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    rd = rdata;
    rs = rresp;
    rready <= 1'b0;
    if (k == 50) num_errors++;
    `CHK(rd, v)
    `CHK(rs, r)
  endtask
  // waits stay bounded so a stuck output cannot hang the run
  task wait_obs(input int i, input logic v, output int c);
    for (c = 0; c < 400; c++) begin
      @(posedge aclk);
      if (obs[i] === v) break;
    end
    if (c == 400) num_errors++;
  endtask
  initial begin
    repeat (20000) @(posedge aclk);
    num_errors++;
    end_sim;
  end
  initial begin
    {aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, sel2} = 8'h00;
    {awaddr, araddr, wdata, skew} = 80'h0;
    stop_n = 1'b1;
    noise = 32'hBD052852;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    `CHK(obs, 3'b000)
    for (int i = 0; i < 6; i++) chk_rd(ra[i], rv[i], `RESP_OKAY);
    chk_rd(8'h28, 32'h0, `RESP_SLVERR);
    `CHK(ax2, 1'b0)
    wr(`OFF_TMAX, `TMAX_LIMIT + 32'h1, rs);
    `CHK(rs, `RESP_SLVERR)
    wr(`OFF_BRAKE_RAMP, 32'h1, rs);
    wr(`OFF_CTRL, 32'h2, rs);
    `CHK(rs, `RESP_SLVERR)
    wr(`OFF_BRAKE_RAMP, `RAMP_MIN_MON, rs);
    wr(`OFF_CTRL, 32'h2, rs);
    wr(`OFF_BRAKE_RAMP, 32'h1, rs);
    `CHK(rs, `RESP_SLVERR)
    d = noise & `MASK_31;
    wr(`OFF_DEC_WIN, d, rs);
    chk_rd(`OFF_DEC_WIN, d, `RESP_OKAY);
    wr(`OFF_DEC_WIN, 32'h5, rs);
    wr(`OFF_IRQ_EN, 32'hF, rs);
    skew <= 32'h6;
    stop_n <= 1'b0;
    wait_obs(2, 1'b1, n);
    `CHK(standstill_ok, 1'b0)
    `CHK(irq, 1'b1)
    stop_n <= 1'b1;
    skew <= 32'h0;
    wait_obs(0, 1'b0, n);
    `CHK(sto, 1'b0)
    wr(`OFF_IRQ_CLR, 32'hF, rs);
    @(posedge aclk);
    `CHK(irq, 1'b0)
    wr(`OFF_CTRL, 32'h0, rs);
    for (t = 3; t < 5; t++) begin
      wr(`OFF_TMAX, t, rs);
      stop_n <= 1'b0;
      wait_obs(0, 1'b1, n);
      `CHK(n <= 11, 1'b1)
      `CHK({dbs, fbs, ramp}, {2'b10, `RAMP_MIN_MON})
      wait_obs(1, 1'b1, nt[t]);
      `CHK(nt[t] + 1 >= 4 * t && nt[t] <= 4 * t + 8, 1'b1)
      skew <= `RST_TOL + 32'h1;
      wait_obs(2, 1'b1, n);
      `CHK(standstill_ok, 1'b0)
      stop_n <= 1'b1;
      skew <= 32'h0;
      wait_obs(0, 1'b0, n);
    end
    `CHK(nt[3], nt[4])
    chk_rd(`OFF_IRQ_STAT, 32'hF, `RESP_OKAY);
    wr(`OFF_IRQ_CLR, 32'hF, rs);
    chk_rd(`OFF_IRQ_CLR, 32'h0, `RESP_OKAY);
    wr(`OFF_IRQ_EN, 32'h0, rs);
    wr(`OFF_CTRL, 32'hD, rs);
    wr(`OFF_TMAX, `TMAX_LIMIT, rs);
    `CHK(ax2, 1'b1)
    sel2 <= 1'b1;
    stop_n <= 1'b0;
    wait_obs(0, 1'b1, n);
    `CHK({fbs, dbs}, 2'b10)
    wait_obs(1, 1'b1, n);
    `CHK(n <= 16, 1'b1)
    chk_rd(`OFF_IRQ_STAT, 32'h3, `RESP_OKAY);
    `CHK(irq, 1'b0)
    wr(`OFF_IRQ_EN, 32'h2, rs);
    @(posedge aclk);
    `CHK(irq, 1'b1)
    stop_n <= 1'b1;
    wait_obs(0, 1'b0, n);
    `CHK(obs, 3'b000)
    end_sim;
  end
endmodule

// ==== sim/motion_model.sv ====
`timescale 1ns/100ps
// ==========================================
// axis seen by the monitor, brakes on request
module motion_model (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire        brake,
  input  wire [31:0] skew,
  output wire [31:0] pos,
  output reg  [31:0] speed,
  output wire [31:0] ramp_pos
);
  reg [31:0] track;
  // skew pushes actual position off the commanded ramp
  assign pos = track + skew;
  assign ramp_pos = track;
  always @(posedge aclk) begin
    if (!aresetn) begin
      track <= 32'h0;
      speed <= 32'h14;
    end else begin
      track <= track + speed;
      if (brake) begin
        if (speed != 32'h0) speed <= speed - 32'h1;
      end else speed <= 32'h14;
    end
  end
endmodule
